// File: parallel_port_pkg.sv
// constants, access types and request/answer carriers for the parallel port bank
// assumes a single ref_clk domain; host requests arrive already on that clock
`default_nettype none
package parallel_port_pkg;
  localparam int          NUM_SLICES    = 8;
  localparam int          ALT_SLICES    = 2;
  localparam int          SLICE_BITS    = 24;
  localparam int          ALL_BITS      = NUM_SLICES * SLICE_BITS;
  localparam int          AUX_BITS      = 8;
  localparam int          SYNC_WIDTH    = ALL_BITS + AUX_BITS;
  localparam logic [15:0] SLICE_STRIDE  = 16'h0004;
  localparam logic [15:0] SLICE_SPAN    = 16'h0020;
  localparam logic [15:0] AUX_OFFSET    = 16'h0020;
  localparam logic [1:0]  SUB_PORT_A    = 2'h0;
  localparam logic [1:0]  SUB_PORT_B    = 2'h1;
  localparam logic [1:0]  SUB_PORT_C    = 2'h2;
  localparam logic [1:0]  SUB_DIRECTION = 2'h3;
  localparam int          POS_A         = 0;
  localparam int          POS_B         = 8;
  localparam int          POS_C_LOW     = 16;
  localparam int          POS_C_HIGH    = 20;
  localparam int          DIR_A         = 0;
  localparam int          DIR_B         = 1;
  localparam int          DIR_C_LOW     = 2;
  localparam int          DIR_C_HIGH    = 3;
  localparam logic [3:0]  DIR_RESET     = 4'h0;
  localparam logic [23:0] OUT_RESET     = 24'h000000;
  localparam logic [7:0]  AUX_RESET     = 8'h00;
  localparam logic        direction_input  = 1'b0;
  localparam logic        direction_output = 1'b1;

  typedef enum logic [1:0] {
    acc_byte,
    acc_word,
    acc_nibble
  } access_size_t;

  typedef struct packed {
    logic         req;
    logic         write;
    access_size_t size;
    logic [15:0]  addr;
    logic [15:0]  wdata;
  } host_req_t;

  typedef struct packed {
    logic        ack;
    logic        err;
    logic [15:0] rdata;
  } host_rsp_t;

  typedef struct packed {
    logic       req;
    logic [7:0] index;
  } bit_req_t;

  typedef struct packed {
    logic valid;
    logic value;
  } bit_rsp_t;
endpackage : parallel_port_pkg
`default_nettype wire

// File: pin_sync.sv
// two-stage synchroniser for the port input lines
// assumes inputs are asynchronous to ref_clk; no logic may read stage one
`default_nettype none
module pin_sync #(
  parameter int WIDTH = parallel_port_pkg::SYNC_WIDTH
) (
  input  wire logic             ref_clk,  // system clock
  input  wire logic             reset,    // async, active high
  input  wire logic [WIDTH-1:0] pin_in,   // raw pin levels
  output logic      [WIDTH-1:0] pin_sync  // synchronised levels
);
  typedef struct packed {
    logic [WIDTH-1:0] stage1;
    logic [WIDTH-1:0] stage2;
  } sync_state_t;

  sync_state_t st;
  sync_state_t next_st;

  always_comb begin
    next_st.stage1 = pin_in;
    next_st.stage2 = st.stage1;
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign pin_sync = st.stage2;
endmodule // pin_sync
`default_nettype wire

// File: configurable_parallel_port_bank.sv
// bank of eight parallel port slices plus a fixed auxiliary port
// assumes host requests and board_base_address on ref_clk; pins are asynchronous
// Functional notes
// - registers decoded relative to board base address
// - byte and word reads return current value
// - byte and word writes store into register
// - eight slices, four bytes apart, to base+28
// - slice ports A8, B8, Clow4, Chigh4 bits
// - alternate chip type: two slices, no Chigh
// - direction set per whole port
// - every port defaults to input
// - direction write clears that slice's outputs
// - other slices' outputs stay untouched
// - auxiliary port always both input and output
// - byte reads 0-255, nibble reads 0-15
// - single bit read: high gives 1
`default_nettype none
module configurable_parallel_port_bank (
  input  wire logic                                   ref_clk,            // 125 MHz clock
  input  wire logic                                   reset,              // async, active high
  input  wire logic [15:0]                            board_base_address, // board base
  input  wire logic                                   alt_chip_type,      // two-slice variant
  input  wire parallel_port_pkg::host_req_t           host_req,           // register request
  output parallel_port_pkg::host_rsp_t                host_rsp,           // register answer
  input  wire parallel_port_pkg::bit_req_t            bit_req,            // single bit read
  output parallel_port_pkg::bit_rsp_t                 bit_rsp,            // single bit answer
  input  wire logic [parallel_port_pkg::ALL_BITS-1:0] port_in,            // line levels
  output logic      [parallel_port_pkg::ALL_BITS-1:0] port_out,           // line drive values
  output logic      [parallel_port_pkg::ALL_BITS-1:0] port_oe_n,          // low while driving
  input  wire logic [parallel_port_pkg::AUX_BITS-1:0] aux_in,             // aux input lines
  output logic      [parallel_port_pkg::AUX_BITS-1:0] fixed_auxiliary_port // aux output lines
);
  typedef struct packed {
    logic [parallel_port_pkg::NUM_SLICES-1:0][23:0] out_val;
    logic [parallel_port_pkg::NUM_SLICES-1:0][3:0]  dir;
    logic [parallel_port_pkg::AUX_BITS-1:0]         aux_out;
    parallel_port_pkg::host_rsp_t                   rsp;
    parallel_port_pkg::bit_rsp_t                    bit_ans;
  } bank_state_t;

  bank_state_t st;
  bank_state_t next_st;

  logic [parallel_port_pkg::SYNC_WIDTH-1:0] pins_sync;
  logic [parallel_port_pkg::ALL_BITS-1:0]   in_sync;
  logic [parallel_port_pkg::AUX_BITS-1:0]   aux_sync;
  logic [parallel_port_pkg::ALL_BITS-1:0]   port_view;
  logic [parallel_port_pkg::NUM_SLICES-1:0] slice_live;

  pin_sync #(
    .WIDTH (parallel_port_pkg::SYNC_WIDTH)
  ) u_pin_sync (
    .ref_clk  (ref_clk),
    .reset    (reset),
    .pin_in   ({aux_in, port_in}),
    .pin_sync (pins_sync)
  );

  assign in_sync  = pins_sync[parallel_port_pkg::ALL_BITS-1:0];
  assign aux_sync = pins_sync[parallel_port_pkg::SYNC_WIDTH-1:parallel_port_pkg::ALL_BITS];

  // per slice: pin drive and the value the host sees
  genvar s;
  generate
    for (s = 0; s < parallel_port_pkg::NUM_SLICES; s++) begin : g_slice
      localparam int B0 = s * parallel_port_pkg::SLICE_BITS;
      logic       live;
      logic [3:0] drv;
      assign live          = !alt_chip_type || (s < parallel_port_pkg::ALT_SLICES);
      assign slice_live[s] = live;
      // chigh is absent on the alternate type, so it never drives there
      assign drv = st.dir[s] & {!alt_chip_type, 3'h7} & {4{live}};
      assign port_oe_n[B0+parallel_port_pkg::POS_A +: 8] =
        {8{!drv[parallel_port_pkg::DIR_A]}};
      assign port_oe_n[B0+parallel_port_pkg::POS_B +: 8] =
        {8{!drv[parallel_port_pkg::DIR_B]}};
      assign port_oe_n[B0+parallel_port_pkg::POS_C_LOW +: 4] =
        {4{!drv[parallel_port_pkg::DIR_C_LOW]}};
      assign port_oe_n[B0+parallel_port_pkg::POS_C_HIGH +: 4] =
        {4{!drv[parallel_port_pkg::DIR_C_HIGH]}};
      assign port_out[B0 +: parallel_port_pkg::SLICE_BITS] = st.out_val[s];
      // output ports read back their latch; input ports read the lines
      assign port_view[B0+parallel_port_pkg::POS_A +: 8] = drv[parallel_port_pkg::DIR_A] ?
        st.out_val[s][parallel_port_pkg::POS_A +: 8] :
        in_sync[B0+parallel_port_pkg::POS_A +: 8];
      assign port_view[B0+parallel_port_pkg::POS_B +: 8] = drv[parallel_port_pkg::DIR_B] ?
        st.out_val[s][parallel_port_pkg::POS_B +: 8] :
        in_sync[B0+parallel_port_pkg::POS_B +: 8];
      assign port_view[B0+parallel_port_pkg::POS_C_LOW +: 4] =
        drv[parallel_port_pkg::DIR_C_LOW] ?
        st.out_val[s][parallel_port_pkg::POS_C_LOW +: 4] :
        in_sync[B0+parallel_port_pkg::POS_C_LOW +: 4];
      assign port_view[B0+parallel_port_pkg::POS_C_HIGH +: 4] = alt_chip_type ? 4'h0 :
        (drv[parallel_port_pkg::DIR_C_HIGH] ?
        st.out_val[s][parallel_port_pkg::POS_C_HIGH +: 4] :
        in_sync[B0+parallel_port_pkg::POS_C_HIGH +: 4]);
    end
  endgenerate

  // one register byte of a slice: A, B, C, then the direction bits
  function automatic logic [7:0] slice_byte(input logic [23:0] view,
                                            input logic [3:0]  dir,
                                            input logic [1:0]  sub);
    logic [7:0] b;
    b = 8'h00;
    case (sub)
      parallel_port_pkg::SUB_PORT_A: b = view[parallel_port_pkg::POS_A +: 8];
      parallel_port_pkg::SUB_PORT_B: b = view[parallel_port_pkg::POS_B +: 8];
      parallel_port_pkg::SUB_PORT_C: b = view[parallel_port_pkg::POS_C_LOW +: 8];
      default:                       b = {4'h0, dir};
    endcase
    return b;
  endfunction

  logic [15:0] offset;
  logic [2:0]  sel;
  logic [1:0]  sub;
  logic        hit_slice;
  logic        hit_aux;
  logic        bad;
  logic [23:0] sel_view;
  logic [3:0]  sel_dir;

  always_comb begin
    offset    = host_req.addr - board_base_address;
    sel       = offset[4:2];
    sub       = offset[1:0];
    hit_slice = (offset < parallel_port_pkg::SLICE_SPAN) && slice_live[sel];
    hit_aux   = (offset == parallel_port_pkg::AUX_OFFSET);
    sel_view  = port_view[sel * parallel_port_pkg::SLICE_BITS +: 24];
    sel_dir   = st.dir[sel];
    // words sit on even offsets; nibbles only at the two port C halves
    bad = !(hit_slice || hit_aux) ||
          ((host_req.size == parallel_port_pkg::acc_word) && sub[0]) ||
          ((host_req.size == parallel_port_pkg::acc_nibble) &&
           (hit_aux || (sub < parallel_port_pkg::SUB_PORT_C) ||
            (alt_chip_type && (sub == parallel_port_pkg::SUB_DIRECTION))));

    next_st               = st;
    next_st.rsp.ack       = 1'b0;
    next_st.rsp.err       = 1'b0;
    next_st.bit_ans.valid = 1'b0;

    if (host_req.req) begin
      next_st.rsp.ack   = 1'b1;
      next_st.rsp.rdata = 16'h0000;
      if (bad) begin
        next_st.rsp.err = 1'b1;
      end else if (hit_aux) begin
        // aux has no direction: always readable and always driven
        if (host_req.write) begin
          next_st.aux_out = host_req.wdata[7:0];
        end else begin
          next_st.rsp.rdata = {8'h00, aux_sync};
        end
      end else if (!host_req.write) begin
        case (host_req.size)
          parallel_port_pkg::acc_word: begin
            next_st.rsp.rdata = {slice_byte(sel_view, sel_dir, sub + 2'h1),
                                 slice_byte(sel_view, sel_dir, sub)};
          end
          parallel_port_pkg::acc_nibble: begin
            next_st.rsp.rdata = (sub == parallel_port_pkg::SUB_PORT_C) ?
              {12'h000, sel_view[parallel_port_pkg::POS_C_LOW +: 4]} :
              {12'h000, sel_view[parallel_port_pkg::POS_C_HIGH +: 4]};
          end
          default: begin
            next_st.rsp.rdata = {8'h00, slice_byte(sel_view, sel_dir, sub)};
          end
        endcase
      end else begin
        case (host_req.size)
          parallel_port_pkg::acc_nibble: begin
            if (sub == parallel_port_pkg::SUB_PORT_C) begin
              next_st.out_val[sel][parallel_port_pkg::POS_C_LOW +: 4] =
                host_req.wdata[3:0];
            end else begin
              next_st.out_val[sel][parallel_port_pkg::POS_C_HIGH +: 4] =
                host_req.wdata[3:0];
            end
          end
          parallel_port_pkg::acc_word: begin
            if (sub == parallel_port_pkg::SUB_PORT_A) begin
              next_st.out_val[sel][parallel_port_pkg::POS_A +: 16] = host_req.wdata;
            end else begin
              // direction byte in the same word wins: the slice is cleared
              next_st.dir[sel] = host_req.wdata[11:8] & {!alt_chip_type, 3'h7};
              next_st.out_val[sel] = parallel_port_pkg::OUT_RESET;
            end
          end
          default: begin
            case (sub)
              parallel_port_pkg::SUB_PORT_A:
                next_st.out_val[sel][parallel_port_pkg::POS_A +: 8] = host_req.wdata[7:0];
              parallel_port_pkg::SUB_PORT_B:
                next_st.out_val[sel][parallel_port_pkg::POS_B +: 8] = host_req.wdata[7:0];
              parallel_port_pkg::SUB_PORT_C:
                next_st.out_val[sel][parallel_port_pkg::POS_C_LOW +: 8] =
                  host_req.wdata[7:0];
              default: begin
                next_st.dir[sel] = host_req.wdata[3:0] & {!alt_chip_type, 3'h7};
                // only the addressed slice is cleared
                next_st.out_val[sel] = parallel_port_pkg::OUT_RESET;
              end
            endcase
          end
        endcase
      end
    end

    if (bit_req.req) begin
      next_st.bit_ans.valid = 1'b1;
      next_st.bit_ans.value = (bit_req.index < 8'(parallel_port_pkg::ALL_BITS)) ?
        port_view[bit_req.index] : 1'b0;
    end
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      st         <= '0;
      st.dir     <= {parallel_port_pkg::NUM_SLICES{parallel_port_pkg::DIR_RESET}};
      st.aux_out <= parallel_port_pkg::AUX_RESET;
    end else begin
      st <= next_st;
    end
  end

  assign host_rsp             = st.rsp;
  assign bit_rsp              = st.bit_ans;
  assign fixed_auxiliary_port = st.aux_out;
endmodule // configurable_parallel_port_bank
`default_nettype wire

// File: port_bank_sva.sv
// timing checks on the parallel port bank, bound to its top ports
// assumes one ref_clk domain; offsets wrap at 16 bits like the decoder
`default_nettype none
module port_bank_sva (
  input wire logic                        ref_clk,              // clock
  input wire logic                        reset,                // async, high
  input wire logic [15:0]                 board_base_address,   // board base
  input wire parallel_port_pkg::host_req_t host_req,            // request
  input wire parallel_port_pkg::host_rsp_t host_rsp,            // answer
  input wire parallel_port_pkg::bit_req_t  bit_req,             // bit request
  input wire parallel_port_pkg::bit_rsp_t  bit_rsp,             // bit answer
  input wire logic [191:0]                port_out,             // drive values
  input wire logic [191:0]                port_oe_n,            // low = driven
  input wire logic [7:0]                  fixed_auxiliary_port  // aux outputs
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] off;
  logic        wr_b;
  assign off  = host_req.addr - board_base_address;
  assign wr_b = host_req.req && host_req.write && host_req.size == parallel_port_pkg::acc_byte;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);
  property p_ack; host_req.req |=> host_rsp.ack; endproperty
  a_ack: assert property (p_ack) else $error("request not answered");
  property p_no_ack; !host_req.req |=> !host_rsp.ack; endproperty
  a_no_ack: assert property (p_no_ack) else $error("answer without request");
  property p_byte_a; wr_b && off == 16'h0000 |=> port_out[7:0] == $past(host_req.wdata[7:0]);
  endproperty
  a_byte_a: assert property (p_byte_a) else $error("port a not stored");
  property p_dir_oe; wr_b && off == 16'h0003 |=> port_oe_n[7:0] == {8{~$past(host_req.wdata[0])}}
    && port_oe_n[15:8] == {8{~$past(host_req.wdata[1])}}; endproperty
  a_dir_oe: assert property (p_dir_oe) else $error("whole port enable wrong");
  property p_clear; wr_b && off == 16'h0003 |=> port_out[23:0] == 24'h000000; endproperty
  a_clear: assert property (p_clear) else $error("slice outputs not cleared");
  property p_other; wr_b && off == 16'h0003 |=> $stable(port_out[191:24]); endproperty
  a_other: assert property (p_other) else $error("other slice disturbed");
  property p_aux; wr_b && off == 16'h0020 |=> fixed_auxiliary_port == $past(host_req.wdata[7:0]);
  endproperty
  a_aux: assert property (p_aux) else $error("aux output not stored");
  property p_unmapped; host_req.req && off > 16'h0020 |=> host_rsp.ack && host_rsp.err; endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped offset accepted");
  property p_odd_word;
    host_req.req && host_req.size == parallel_port_pkg::acc_word && off[0] |=> host_rsp.err;
  endproperty
  a_odd_word: assert property (p_odd_word) else $error("odd word accepted");
  property p_bit; bit_req.req |=> bit_rsp.valid; endproperty
  a_bit: assert property (p_bit) else $error("bit read not answered");
endmodule // port_bank_sva
`default_nettype wire

// File: line_equipment.sv
// model of the equipment wired to the port lines
// assumes port_oe_n low marks a line the bank drives
`default_nettype none
module line_equipment (
  input  wire logic [191:0] port_out,  // bank drive values
  input  wire logic [191:0] port_oe_n, // low while bank drives
  input  wire logic [191:0] pattern,   // levels the equipment drives
  output logic      [191:0] port_in    // resolved line levels
);
  timeunit 1ns;
  timeprecision 1ps;
  // released lines show the equipment, driven ones read back the bank
  always_comb port_in = (port_oe_n & pattern) | (~port_oe_n & port_out);
endmodule // line_equipment
`default_nettype wire

// File: tb_configurable_parallel_port_bank.sv
// self-checking bench for the parallel port bank with a line model
// assumes the package, design and checker are compiled first
`default_nettype none
module tb_configurable_parallel_port_bank;
  timeunit 1ns;
  timeprecision 1ps;
  localparam parallel_port_pkg::access_size_t by = parallel_port_pkg::acc_byte;
  localparam parallel_port_pkg::access_size_t wd = parallel_port_pkg::acc_word;
  localparam parallel_port_pkg::access_size_t nb = parallel_port_pkg::acc_nibble;
  logic                          ref_clk;
  logic                          reset;
  logic [15:0]                   board_base_address;
  logic                          alt_chip_type;
  parallel_port_pkg::host_req_t  host_req;
  parallel_port_pkg::host_rsp_t  host_rsp;
  parallel_port_pkg::bit_req_t   bit_req;
  parallel_port_pkg::bit_rsp_t   bit_rsp;
  logic [191:0]                  port_in;
  logic [191:0]                  port_out;
  logic [191:0]                  port_oe_n;
  logic [191:0]                  pattern;
  logic [7:0]                    aux_in;
  logic [7:0]                    aux_out;
  int                            failures;
  int                            checks_done;
  configurable_parallel_port_bank i_configurable_parallel_port_bank (.ref_clk, .reset,
    .board_base_address, .alt_chip_type, .host_req, .host_rsp, .bit_req, .bit_rsp,
    .port_in, .port_out, .port_oe_n, .aux_in, .fixed_auxiliary_port(aux_out));
  line_equipment i_line_equipment (.port_out, .port_oe_n, .pattern, .port_in);
  task automatic complete_run();
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic check(string what, logic [191:0] exp, logic [191:0] got);
    checks_done++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] %s expected %0h seen %0h", what, exp, got);
    end
  endtask
  // one request, held to the sampling edge, answer read while ack stands
  task automatic access(logic w, parallel_port_pkg::access_size_t sz, logic [15:0] off,
                        logic [15:0] wdat, logic [15:0] exp, logic ee);
    int n;
    host_req <= '{1'h1, w, sz, board_base_address + off, wdat};
    @(negedge ref_clk);
    host_req.req <= 1'h0;
    for (n = 0; n < 4 && host_rsp.ack !== 1'h1; n++) @(negedge ref_clk);
    if (n == 4) check("ack", 1'h1, 1'h0);
    if (n == 4) complete_run();
    check("err", ee, host_rsp.err);
    if (!w && !ee) check("rdata", exp, host_rsp.rdata);
    @(negedge ref_clk);
  endtask
  task automatic bit_read(logic [7:0] idx, logic exp);
    bit_req <= '{1'h1, idx};
    @(negedge ref_clk);
    bit_req.req <= 1'h0;
    check("valid", 1'h1, bit_rsp.valid);
    check("bit", exp, bit_rsp.value);
    @(negedge ref_clk);
  endtask
  initial begin
    ref_clk = 1'h0;
    forever #4 ref_clk = ~ref_clk;
  end
  initial begin
    failures = 0;
    checks_done = 0;
    reset = 1'h1;
    board_base_address = 16'h0300;
    alt_chip_type = 1'h0;
    host_req = '0;
    bit_req = '0;
    aux_in = 8'h3C;
    pattern = {24{8'hA6}};
    repeat (5) @(negedge ref_clk);
    reset <= 1'h0;
    @(negedge ref_clk);
    check("oe_n", {192{1'h1}}, port_oe_n);
    check("out", '0, port_out);
    access(1'h0, by, 16'h0003, 16'h0, 16'h0000, 1'h0);
    access(1'h0, by, 16'h0000, 16'h0, 16'h00A6, 1'h0);
    $display("reset test done");
    for (int s = 0; s < 8; s++) begin
      access(1'h1, by, 16'(4 * s + 3), 16'h000F, 16'h0, 1'h0);
      access(1'h1, by, 16'(4 * s), 16'(8'h10 + s), 16'h0, 1'h0);
      access(1'h1, by, 16'(4 * s + 2), 16'h00B7, 16'h0, 1'h0);
      access(1'h0, wd, 16'(4 * s + 2), 16'h0, 16'h0FB7, 1'h0);
      check("slice", 24'hB70010 + s, port_out[24 * s +: 24]);
      check("oe_n", 24'h0, port_oe_n[24 * s +: 24]);
    end
    $display("slice map test done");
    // slice 3 keeps only port a as output, so its others become inputs
    access(1'h1, by, 16'h000F, 16'h0001, 16'h0, 1'h0);
    check("cleared", 24'h0, port_out[95:72]);
    check("kept", 24'hB70012, port_out[71:48]);
    check("oe_n", 24'hFFFF00, port_oe_n[95:72]);
    access(1'h1, wd, 16'h0000, 16'hC35A, 16'h0, 1'h0);
    access(1'h0, wd, 16'h0000, 16'h0, 16'hC35A, 1'h0);
    check("word out", 16'hC35A, port_out[15:0]);
    $display("direction test done");
    access(1'h0, nb, 16'h000E, 16'h0, 16'h0006, 1'h0);
    access(1'h0, nb, 16'h000F, 16'h0, 16'h000A, 1'h0);
    access(1'h0, by, 16'h000D, 16'h0, 16'h00A6, 1'h0);
    access(1'h0, by, 16'h000C, 16'h0, 16'h0000, 1'h0);
    bit_read(8'd81, 1'h1);
    bit_read(8'd80, 1'h0);
    bit_read(8'd1, 1'h1);
    bit_read(8'd192, 1'h0);
    $display("input test done");
    access(1'h1, by, 16'h0020, 16'h00A5, 16'h0, 1'h0);
    check("aux", 8'hA5, aux_out);
    access(1'h0, by, 16'h0020, 16'h0, 16'h003C, 1'h0);
    access(1'h0, by, 16'h0021, 16'h0, 16'h0, 1'h1);
    access(1'h0, wd, 16'h0001, 16'h0, 16'h0, 1'h1);
    access(1'h0, nb, 16'h0000, 16'h0, 16'h0, 1'h1);
    board_base_address <= 16'h1000;
    @(negedge ref_clk);
    access(1'h0, wd, 16'h0000, 16'h0, 16'hC35A, 1'h0);
    // nibble writes land in their own half of port c only
    access(1'h1, nb, 16'h0002, 16'h000C, 16'h0, 1'h0);
    access(1'h1, nb, 16'h0003, 16'h0009, 16'h0, 1'h0);
    check("nibbles", 24'h9CC35A, port_out[23:0]);
    // direction by word: c byte is dropped and the slice cleared
    access(1'h1, wd, 16'h0002, 16'h0355, 16'h0, 1'h0);
    check("word cleared", 24'h0, port_out[23:0]);
    check("word oe_n", 24'hFF0000, port_oe_n[23:0]);
    // let the released c lines pass the synchroniser
    @(negedge ref_clk);
    access(1'h0, wd, 16'h0002, 16'h0, 16'h03A6, 1'h0);
    $display("aux and decode test done");
    alt_chip_type <= 1'h1;
    @(negedge ref_clk);
    access(1'h0, by, 16'h0008, 16'h0, 16'h0, 1'h1);
    access(1'h0, nb, 16'h0003, 16'h0, 16'h0, 1'h1);
    access(1'h1, by, 16'h0003, 16'h000F, 16'h0, 1'h0);
    access(1'h0, by, 16'h0003, 16'h0, 16'h0007, 1'h0);
    $display("variant test done");
    complete_run();
  end
endmodule // tb_configurable_parallel_port_bank
bind configurable_parallel_port_bank port_bank_sva i_port_bank_sva (.ref_clk, .reset,
  .board_base_address, .host_req, .host_rsp, .bit_req, .bit_rsp, .port_out, .port_oe_n,
  .fixed_auxiliary_port);
`default_nettype wire
